// *** cdta_monitor.sv ***
// Console debug monitor: polls the console serial unit and interprets terminal commands
`timescale 1ns/100ps
`include "cdta_defs.svh"
module cdta_monitor
  import cdta_pkg::*;
(
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  // Halt request pin from outside the clock domain
  input  wire logic                    haltPin,
  // Page mapping, eight 16-bit page bases in 64-byte units
  input  wire logic [127:0]            pageBases,
  // Private memory link bus master
  output logic                         busReq,
  output logic                         busWrite,
  output logic                         busByte,
  output logic [`CDTA_ADDR_W-1:0]      busAddr,
  output logic [`CDTA_DATA_W-1:0]      busWdata,
  input  wire logic                    busAck,
  input  wire logic [`CDTA_DATA_W-1:0] busRdata,
  // Status
  output logic                         run_indicator_n,
  output logic                         monitorActive,
  output logic                         consoleHung
);

  cdta_seq_t             seq;
  logic [2:0]            haltSync;
  logic                  haltSeen;
  logic [63:0]           prBuf;       // Pending output, low byte first
  logic [3:0]            prCnt;
  logic [21:0]           addrAcc;
  logic [15:0]           dataAcc;
  logic                  haveAddr;
  logic                  dataTyped;
  logic                  isOpen;
  logic                  lastClosed;
  logic                  virt;
  logic                  memWr;
  logic                  fifoInValid;
  logic                  fifoInReady;
  logic [7:0]            fifoInData;
  logic                  fifoOutValid;
  logic                  fifoOutReady;
  logic [7:0]            fifoOutData;
  logic [6:0]            ch;
  logic [15:0]           pageBase;
  logic [21:0]           memAddr;
  logic [47:0]           digits;

  // Receive characters queue here, but polling waits for an empty queue, so the poller never runs ahead of the parser
  cdta_fifo #(
    .WIDTH (8),
    .DEPTH (`CDTA_FIFO_DEPTH)
  ) u_rxq (
    .clk      (clk),
    .rst_n    (rst_n),
    .inValid  (fifoInValid),
    .inReady  (fifoInReady),
    .inData   (fifoInData),
    .outValid (fifoOutValid),
    .outReady (fifoOutReady),
    .outData  (fifoOutData)
  );

  // Halt pin synchroniser; only stages two and three are looked at
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      haltSync <= 3'h0;
      haltSeen <= 1'b0;
    end else begin
      haltSync <= {haltSync[1:0], haltPin};
      if (haltSync[1] == haltSync[2]) begin
        haltSeen <= haltSync[2];
      end
    end
  end

  // Parity bit kept for echo but ignored when matching commands
  assign ch = fifoOutData[6:0];
  // Parser pops only when nothing is waiting to print
  assign fifoOutReady = (seq == SQ_DISPATCH) && (prCnt == 4'h0);

  // translate a virtual address through the page base of its 8 Kbyte page
  assign pageBase = pageBases[16*addrAcc[15:13] +: 16];
  // physical addresses pass through at full 22-bit width
  assign memAddr  = virt ? ({pageBase, 6'h00} + {9'h000, addrAcc[12:0]}) : addrAcc;

  // Six octal digits of the word just read
  assign digits = {5'b00110, busRdata[2:0],   5'b00110, busRdata[5:3],
                   5'b00110, busRdata[8:6],   5'b00110, busRdata[11:9],
                   5'b00110, busRdata[14:12], 5'b00110, 2'b00, busRdata[15]};

  // Run light follows the sequencer; low while instructions execute
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_indicator_n <= 1'b1;
      monitorActive   <= 1'b0;
    end else begin
      run_indicator_n <= (seq != SQ_RUN);
      monitorActive   <= (seq != SQ_RUN) && (seq != SQ_HUNG);
    end
  end

  // Sequencer, bus master and command parser share one process since each bus cycle is a sequencer step
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      seq         <= SQ_ENTER;
      busReq      <= 1'b0;
      busWrite    <= 1'b0;
      busByte     <= 1'b0;
      busAddr     <= '0;
      busWdata    <= '0;
      prBuf       <= '0;
      prCnt       <= 4'h0;
      addrAcc     <= '0;
      dataAcc     <= '0;
      haveAddr    <= 1'b0;
      dataTyped   <= 1'b0;
      isOpen      <= 1'b0;
      lastClosed  <= 1'b0;
      virt        <= 1'b0;
      memWr       <= 1'b0;
      fifoInValid <= 1'b0;
      fifoInData  <= 8'h00;
      consoleHung <= 1'b0;
    end else begin
      fifoInValid <= 1'b0;
      case (seq)
        SQ_RUN: begin
          if (haltSeen) begin
            seq <= SQ_ENTER;
          end
        end
        SQ_ENTER: begin
          // one throw-away receive buffer read at a fixed console address
          busReq   <= 1'b1;
          busWrite <= 1'b0;
          busByte  <= 1'b1;
          busAddr  <= `CDTA_RCV_BUF_ADDR;
          isOpen   <= 1'b0;
          haveAddr <= 1'b0;
          lastClosed <= 1'b0;
          seq      <= SQ_FLUSH;
        end
        SQ_FLUSH: begin
          if (busAck) begin
            busReq <= 1'b0;
            prBuf  <= {40'h0, `CDTA_CH_AT, `CDTA_CH_LF, `CDTA_CH_CR};
            prCnt  <= 4'h3;
            seq    <= SQ_DISPATCH;
          end
        end
        SQ_DISPATCH: begin
          busByte <= 1'b1;
          // printing has priority; no receive polling while output is pending
          if (prCnt != 4'h0) begin
            busReq   <= 1'b1;
            busWrite <= 1'b0;
            busAddr  <= `CDTA_XMT_STAT_ADDR;
            seq      <= SQ_TXST;
          end else if (fifoOutValid) begin
            // each queued character is a command character
            if (ch >= 7'h30 && ch <= 7'h37) begin
              if (isOpen) begin
                dataAcc   <= {dataAcc[12:0], ch[2:0]};
                dataTyped <= 1'b1;
              end else begin
                addrAcc  <= haveAddr ? {addrAcc[18:0], ch[2:0]} : {19'h0, ch[2:0]};  // Fresh address per entry
                haveAddr <= 1'b1;
              end
              prBuf <= {56'h0, fifoOutData};
              prCnt <= 4'h1;
            end else if (ch == 7'(`CDTA_CH_V)) begin
              virt  <= 1'b1;
              prBuf <= {56'h0, fifoOutData};
              prCnt <= 4'h1;
            end else if (ch == 7'(`CDTA_CH_SLASH) && !isOpen && (haveAddr || lastClosed)) begin
              busReq    <= 1'b1;
              busWrite  <= 1'b0;
              busByte   <= 1'b0;
              busAddr   <= memAddr;
              addrAcc   <= memAddr;  // Kept physical so a bare slash later reopens the same word
              virt      <= 1'b0;
              memWr     <= 1'b0;
              seq       <= SQ_MEM;
            end else if ((ch == 7'(`CDTA_CH_CR) || ch == 7'(`CDTA_CH_LF)) && isOpen && dataTyped) begin
              busReq   <= 1'b1;
              busWrite <= 1'b1;
              busByte  <= 1'b0;
              busAddr  <= memAddr;
              busWdata <= dataAcc;
              memWr    <= 1'b1;
              seq      <= SQ_MEM;
            end else if (ch == 7'(`CDTA_CH_CR) || ch == 7'(`CDTA_CH_LF)) begin
              // Line feed is not echoed; both close and prompt again
              lastClosed <= isOpen;
              isOpen     <= 1'b0;
              haveAddr   <= 1'b0;
              virt       <= 1'b0;
              prBuf      <= {40'h0, `CDTA_CH_AT, `CDTA_CH_LF, `CDTA_CH_CR};
              prCnt      <= 4'h3;
            end else if ((ch == 7'(`CDTA_CH_G) || ch == 7'(`CDTA_CH_P)) && !isOpen) begin
              seq <= SQ_RUN;
            end else begin
              isOpen     <= 1'b0;
              haveAddr   <= 1'b0;
              lastClosed <= 1'b0;
              virt       <= 1'b0;
              prBuf      <= {32'h0, `CDTA_CH_AT, `CDTA_CH_LF, `CDTA_CH_CR, `CDTA_CH_QM};
              prCnt      <= 4'h4;
            end
          end else if (fifoInReady && !fifoInValid) begin
            // poll receive status; FIFO full stalls polling here
            busReq   <= 1'b1;
            busWrite <= 1'b0;
            busAddr  <= `CDTA_RCV_STAT_ADDR;
            seq      <= SQ_RXST;
          end
        end
        SQ_RXST: begin
          if (busAck) begin
            // only the done bit counts, interrupt enable ignored
            if (busRdata[`CDTA_DONE_BIT]) begin
              busAddr <= `CDTA_RCV_BUF_ADDR;
              seq     <= SQ_RXBUF;
            end else begin
              busReq <= 1'b0;
              seq    <= SQ_DISPATCH;
            end
          end
        end
        SQ_RXBUF: begin
          if (busAck) begin
            // low byte only, parity bit kept for echo
            busReq      <= 1'b0;
            fifoInValid <= 1'b1;
            fifoInData  <= busRdata[7:0];
            seq         <= SQ_DISPATCH;
          end
        end
        SQ_TXST: begin
          if (busAck) begin
            // loopback or break set leaves the console dead until reset
            if (busRdata[`CDTA_LOOP_BIT] || busRdata[`CDTA_BREAK_BIT]) begin
              busReq      <= 1'b0;
              consoleHung <= 1'b1;
              seq         <= SQ_HUNG;
            // wait for transmit done, then write the character
            end else if (busRdata[`CDTA_DONE_BIT]) begin
              busWrite <= 1'b1;
              busAddr  <= `CDTA_XMT_BUF_ADDR;
              busWdata <= {8'h00, prBuf[7:0]};
              seq      <= SQ_TXBUF;
            end else begin
              busReq <= 1'b0;
              seq    <= SQ_DISPATCH;
            end
          end
        end
        SQ_TXBUF: begin
          if (busAck) begin
            busReq   <= 1'b0;
            busWrite <= 1'b0;
            prBuf    <= {8'h00, prBuf[63:8]};
            prCnt    <= prCnt - 4'h1;
            seq      <= SQ_DISPATCH;
          end
        end
        SQ_MEM: begin
          if (busAck) begin
            busReq   <= 1'b0;
            busWrite <= 1'b0;
            if (memWr) begin
              isOpen     <= 1'b0;
              dataTyped  <= 1'b0;
              haveAddr   <= 1'b0;
              lastClosed <= 1'b1;
              virt       <= 1'b0;
              prBuf      <= {40'h0, `CDTA_CH_AT, `CDTA_CH_LF, `CDTA_CH_CR};
              prCnt      <= 4'h3;
            end else begin
              isOpen    <= 1'b1;
              dataTyped <= 1'b0;
              dataAcc   <= 16'h0000;
              prBuf     <= {`CDTA_CH_SPACE, digits, `CDTA_CH_SLASH};
              prCnt     <= 4'h8;
            end
            seq <= SQ_DISPATCH;
          end
        end
        SQ_HUNG: begin
          seq <= SQ_HUNG;
        end
        default: begin
          seq <= SQ_ENTER;
        end
      endcase
    end
  end

endmodule : cdta_monitor

// *** cdta_defs.svh ***
// Constants for the console debug terminal access block
`ifndef CDTA_DEFS_SVH
`define CDTA_DEFS_SVH

// Console register bus addresses (17777560..17777566 octal)
`define CDTA_RCV_STAT_ADDR 22'h3FFF70
`define CDTA_RCV_BUF_ADDR  22'h3FFF72
`define CDTA_XMT_STAT_ADDR 22'h3FFF74
`define CDTA_XMT_BUF_ADDR  22'h3FFF76

// Status bit positions
`define CDTA_DONE_BIT      7
`define CDTA_INTEN_BIT     6
`define CDTA_LOOP_BIT      2
`define CDTA_BREAK_BIT     0

// Address and data widths
`define CDTA_ADDR_W        22
`define CDTA_DATA_W        16

// Characters
`define CDTA_CH_CR         8'h0D
`define CDTA_CH_LF         8'h0A
`define CDTA_CH_AT         8'h40
`define CDTA_CH_QM         8'h3F
`define CDTA_CH_SLASH      8'h2F
`define CDTA_CH_SPACE      8'h20
`define CDTA_CH_G          8'h47
`define CDTA_CH_P          8'h50
`define CDTA_CH_V          8'h56

// Receive FIFO depth
`define CDTA_FIFO_DEPTH    32

`endif

// *** cdta_pkg.sv ***
// Types for the console debug terminal access block
package cdta_pkg;

  // Monitor sequencer states
  typedef enum logic [3:0] {
    SQ_RUN,
    SQ_ENTER,
    SQ_FLUSH,
    SQ_DISPATCH,
    SQ_RXST,
    SQ_RXBUF,
    SQ_TXST,
    SQ_TXBUF,
    SQ_MEM,
    SQ_HUNG
  } cdta_seq_t;

endpackage : cdta_pkg

// *** cdta_fifo.sv ***
// Parameterised FIFO holding received console characters
`timescale 1ns/100ps
module cdta_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic [AW:0]      count;
  logic             doPush;
  logic             doPop;

  // Honest full and empty straight from the count
  assign inReady  = (count != (AW+1)'(DEPTH));
  assign outValid = (count != '0);
  assign outData  = mem[rdPtr];
  assign doPush   = inValid && inReady;
  assign doPop    = outValid && outReady;

  // Storage write
  always_ff @(posedge clk) begin
    if (doPush) begin
      mem[wrPtr] <= inData;
    end
  end

  // Pointers and occupancy; pointers wrap at DEPTH so DEPTH need not be a power of two
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (doPush) begin
        wrPtr <= (wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
      end
      if (doPop) begin
        rdPtr <= (rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
      end
      if (doPush && !doPop) begin
        count <= count + 1'b1;
      end else if (doPop && !doPush) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule : cdta_fifo

// *** cdta_checker.sv ***
// Port checker for the console debug monitor
`timescale 1ns/100ps
`include "cdta_defs.svh"
module cdta_checker (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // Bus master side
  input wire logic        busReq,
  input wire logic        busWrite,
  input wire logic        busByte,
  input wire logic [21:0] busAddr,
  input wire logic [15:0] busWdata,
  input wire logic        busAck,
  input wire logic [15:0] busRdata,
  // Status
  input wire logic        run_indicator_n,
  input wire logic        monitorActive,
  input wire logic        consoleHung
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Completed status reads; interrupt enable is deliberately not looked at
  sequence sRxDone;
    busAck && !busWrite && busAddr == `CDTA_RCV_STAT_ADDR && busRdata[7];
  endsequence
  sequence sTxDone;
    busAck && !busWrite && busAddr == `CDTA_XMT_STAT_ADDR && busRdata[7] && !busRdata[2] && !busRdata[0];
  endsequence
  sequence sTxBad;
    busAck && !busWrite && busAddr == `CDTA_XMT_STAT_ADDR && (busRdata[2] || busRdata[0]);
  endsequence

  a_console_window: assert property (busReq && busByte |-> busAddr >= `CDTA_RCV_STAT_ADDR && busAddr <= `CDTA_XMT_BUF_ADDR)
    else $error("byte access outside the console registers");
  a_rx_chain: assert property (sRxDone |=> busReq && !busWrite && busAddr == `CDTA_RCV_BUF_ADDR)
    else $error("receive buffer not read after done");
  a_tx_chain: assert property (sTxDone |=> busReq && busWrite && busByte && busAddr == `CDTA_XMT_BUF_ADDR)
    else $error("transmit buffer not written after done");
  a_tx_needs_done: assert property ($rose(busWrite) && busAddr == `CDTA_XMT_BUF_ADDR
    |-> $past(busRdata[7]) && $past(busAddr) == `CDTA_XMT_STAT_ADDR)
    else $error("transmit write without a done status");
  a_req_stands: assert property (busReq && !busAck |=> busReq && $stable(busAddr) && $stable(busWrite) && $stable(busWdata))
    else $error("request changed before acknowledge");
  a_hang_entry: assert property (sTxBad |=> consoleHung && !busReq)
    else $error("bad transmit status did not hang the console");
  a_hang_sticky: assert property (consoleHung |=> consoleHung && !busReq && !monitorActive)
    else $error("hung console became active again");
  a_run_light: assert property ($past(rst_n) |-> run_indicator_n == (monitorActive || consoleHung))
    else $error("run indicator disagrees with execution state");
  a_entry_flush: assert property ($rose(monitorActive) |-> ##[0:3] (busReq && !busWrite && busAddr == `CDTA_RCV_BUF_ADDR))
    else $error("entry did not start with a receive buffer read");
endmodule : cdta_checker

bind cdta_monitor cdta_checker i_cdta_checker (.clk(clk), .rst_n(rst_n), .busReq(busReq), .busWrite(busWrite),
  .busByte(busByte), .busAddr(busAddr), .busWdata(busWdata), .busAck(busAck), .busRdata(busRdata),
  .run_indicator_n(run_indicator_n), .monitorActive(monitorActive), .consoleHung(consoleHung));

// *** cdta_slu_model.sv ***
// Behavioural console serial unit and memory answering the monitor's bus
`timescale 1ns/100ps
`include "cdta_defs.svh"
module cdta_slu_model (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // Bus slave side
  input wire logic        busReq,
  input wire logic        busWrite,
  input wire logic [21:0] busAddr,
  input wire logic [15:0] busWdata,
  output logic            busAck,
  output logic [15:0]     busRdata
);
  // Knobs and logs handled by the testbench
  int          ackDelay = 0;
  int          txBusy   = 0;
  logic        ieBit    = 1'b0;
  logic        badTx    = 1'b0;
  logic [7:0]  rxq[$];
  logic [7:0]  txq[$];
  logic [15:0] mem[int];
  int          waitCnt  = 0;
  int          txWait   = 0;

  // One answer per request after the chosen wait; idle data toggles so stale values never pass
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busAck   <= 1'b0;
      busRdata <= 16'h0000;
      waitCnt = 0;
    end else if (busAck || !busReq) begin
      busAck   <= 1'b0;
      busRdata <= ~busRdata;
      waitCnt = 0;
    end else if (waitCnt < ackDelay) begin
      busRdata <= ~busRdata;
      waitCnt++;
    end else begin
      busAck <= 1'b1;
      case (busAddr)
        // Done while a key waits; enable and noise bits set to prove they are ignored
        `CDTA_RCV_STAT_ADDR: busRdata <= {8'hA5, rxq.size() != 0, ieBit, 6'h2A};
        // Character in the low byte, noise above
        `CDTA_RCV_BUF_ADDR: busRdata <= {8'hC3, rxq.size() != 0 ? rxq.pop_front() : 8'h00};
        // Loopback and break stay clear unless a scenario breaks the rule
        `CDTA_XMT_STAT_ADDR: begin
          busRdata <= {8'h5A, txWait == 0, ieBit, 3'b101, badTx, 1'b1, 1'b0};
          if (txWait > 0) txWait--;
        end
        // Transmitter takes the low byte and goes busy
        `CDTA_XMT_BUF_ADDR: begin
          txq.push_back(busWdata[7:0]);
          txWait = txBusy;
        end
        default: if (busWrite) mem[busAddr] = busWdata; else busRdata <= mem.exists(busAddr) ? mem[busAddr] : 16'h0000;
      endcase
    end
  end
endmodule : cdta_slu_model

// *** tb_console_debug_terminal_access.sv ***
// Self-checking bench for the console debug monitor
`timescale 1ns/100ps
`include "cdta_defs.svh"
module tb_console_debug_terminal_access;
  logic         clk       = 1'b0;
  logic         rst_n     = 1'b0;
  logic         haltPin   = 1'b0;
  logic [127:0] pageBases = 128'h0100;
  logic         busReq, busWrite, busByte, busAck, run_indicator_n, monitorActive, consoleHung;
  logic [21:0]  busAddr;
  logic [15:0]  busWdata, busRdata;
  int           miscompares = 0;
  int           check_count = 0;
  logic         rxPoll;

  // 125 MHz clock
  always #4 clk = ~clk;

  // Receive polling resumes only once the monitor has nothing left to print
  assign rxPoll = busReq && (busAddr == `CDTA_RCV_STAT_ADDR);

  // Design and far-side model
  cdta_monitor i_cdta_monitor (.clk(clk), .rst_n(rst_n), .haltPin(haltPin), .pageBases(pageBases),
    .busReq(busReq), .busWrite(busWrite), .busByte(busByte), .busAddr(busAddr), .busWdata(busWdata),
    .busAck(busAck), .busRdata(busRdata), .run_indicator_n(run_indicator_n),
    .monitorActive(monitorActive), .consoleHung(consoleHung));
  cdta_slu_model i_cdta_slu_model (.clk(clk), .rst_n(rst_n), .busReq(busReq), .busWrite(busWrite),
    .busAddr(busAddr), .busWdata(busWdata), .busAck(busAck), .busRdata(busRdata));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic results;
    $display("Checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results

  // Bounded waits; running out counts as a mismatch and ends the run
  task automatic waitTx(input int n);
    int k;
    for (k = 0; k < 20000 && i_cdta_slu_model.txq.size() < n; k++) @(posedge clk);
    if (k == 20000) begin
      miscompares++;
      results();
    end
  endtask : waitTx

  task automatic waitState(input logic active);
    int k;
    for (k = 0; k < 20000 && monitorActive !== active; k++) @(posedge clk);
    if (k == 20000) begin
      miscompares++;
      results();
    end
  endtask : waitState

  // Types keys one at a time and compares the expected text with the first characters printed
  task automatic typeExpect(input string in, input string out);
    int k;
    i_cdta_slu_model.txq.delete();
    foreach (in[i]) begin
      @(negedge clk);
      i_cdta_slu_model.rxq.push_back(in[i]);
      // Next key only once this one is taken and its echo has gone out
      for (k = 0; k < 20000 && (i_cdta_slu_model.rxq.size() != 0 || (i + 1 < in.len() && !rxPoll));
           k++) @(posedge clk);
      if (k == 20000) begin
        miscompares++;
        results();
      end
    end
    waitTx(out.len());
    foreach (out[i]) check(i_cdta_slu_model.txq[i], out[i]);
  endtask : typeExpect

  // Main sequence: slow unit with interrupt enables set throughout
  initial begin
    i_cdta_slu_model.ackDelay = 3;
    i_cdta_slu_model.txBusy = 2;
    i_cdta_slu_model.ieBit = 1'b1;
    i_cdta_slu_model.mem[22'h3C0000] = 16'o012525;
    i_cdta_slu_model.mem[22'h004400] = 16'o001234;
    i_cdta_slu_model.mem[22'h00000A] = 16'o177777;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    typeExpect("", "\015\012@");
    check(monitorActive, 1'b1);
    check(run_indicator_n, 1'b1);
    typeExpect("/", "?\015\012@");
    typeExpect("17000000/", "17000000/012525 ");
    typeExpect("777\015", "777\015\012@");
    check(i_cdta_slu_model.mem[22'h3C0000], 16'o000777);
    typeExpect("V2000/", "V2000/001234 ");
    typeExpect("\015", "\015\012@");
    typeExpect("/", "/001234 ");
    typeExpect("\015", "\015\012@");
    // A short address after a long one, then closed by line feed which is not echoed
    typeExpect("12/", "12/177777 ");
    typeExpect("\012", "\015\012@");
    // Go, then a stale key while running that entry must throw away
    typeExpect("G", "");
    waitState(1'b0);
    check(run_indicator_n, 1'b0);
    i_cdta_slu_model.rxq.push_back(8'h58);
    @(posedge clk) haltPin <= 1'b1;
    waitState(1'b1);
    haltPin <= 1'b0;
    typeExpect("", "\015\012@");
    check(i_cdta_slu_model.rxq.size(), 32'h0000_0000);
    // Proceed leaves the monitor the same way, and a halt brings it back
    typeExpect("P", "");
    waitState(1'b0);
    check(run_indicator_n, 1'b0);
    @(posedge clk) haltPin <= 1'b1;
    waitState(1'b1);
    haltPin <= 1'b0;
    typeExpect("", "\015\012@");
    // Loopback flag on the transmitter hangs the console until reset
    i_cdta_slu_model.badTx = 1'b1;
    typeExpect("1", "");
    waitState(1'b0);
    check(consoleHung, 1'b1);
    check(run_indicator_n, 1'b1);
    @(posedge clk) rst_n <= 1'b0;
    repeat (10) @(posedge clk);
    i_cdta_slu_model.badTx = 1'b0;
    rst_n <= 1'b1;
    typeExpect("", "\015\012@");
    check(consoleHung, 1'b0);
    results();
  end
endmodule : tb_console_debug_terminal_access
